// [source_status_block_builder.sv]
// Source status block builder with capability fields, transmitter and registers.
`timescale 1ns/1ps
module source_status_block_builder (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Request from the partner protocol logic
  input wire logic status_req,
  // Status block byte stream out
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_first,
  output logic tx_last,
  output logic [8:0] tx_size,
  input wire logic tx_ready,
  // Interrupt
  output logic irq
);
  import status_pkg::*;

  // Software configuration and live state registers.
  logic [2:0] cap_cfg_r;
  logic [7:0] batt_cnt_r;
  logic [10:0] live_r;
  logic [7:0] temp_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [31:0] rdata_r;

  // Transmitter state.
  tx_state_t state_r;
  tx_state_t state_nxt;
  logic [1:0] idx_r;
  logic [1:0] idx_nxt;
  logic pend_r;
  logic [7:0] blk_r [0:2];
  logic [7:0] tx_data_r;

  // Encoded fields.
  logic [7:0] inputs_byte;
  logic [7:0] batt_byte;
  logic [7:0] present_byte;
  logic [7:0] battin_byte;

  // Capability source-inputs and batteries bytes, built from the configuration word.
  cap_fields u_cap (
    .ext_ok(cap_cfg_r[CAP_EXT_BIT]),
    .uncon_ok(cap_cfg_r[CAP_UNCON_BIT]),
    .batt_ok(cap_cfg_r[CAP_BATT_BIT]),
    .hot_cnt(batt_cnt_r[7:4]),
    .fixed_cnt(batt_cnt_r[3:0]),
    .inputs_byte(inputs_byte),
    .batt_byte(batt_byte)
  );

  // Present-input and battery-input bytes, built from the live supply state.
  status_fields u_stat (
    .ext_cap(cap_cfg_r[CAP_EXT_BIT]),
    .ac_supply(live_r[0]),
    .batt_on(live_r[1]),
    .nonbatt_on(live_r[2]),
    .batt_mask(live_r[10:3]),
    .present_byte(present_byte),
    .battin_byte(battin_byte)
  );

  // Register map of the plain register port, one word per four byte addresses.
  //   CAP_CFG_OFS    read-write  [0] external supply, [1] unconstrained, [2] battery.
  //   BATT_CNT_OFS   read-write  [7:4] hot-swappable count, [3:0] fixed count.
  //   LIVE_OFS       read-write  [0] AC input, [1] battery supplying, [2] other internal
  //                              source supplying, [10:3] supplying battery flags.
  //   TEMP_OFS       read-write  internal temperature byte as sent in the block.
  //   CAPS_RD_OFS    read-only   {batteries byte, source-inputs byte}.
  //   STATUS_RD_OFS  read-only   {battery-input, present-input, temperature} bytes.
  //   IRQ_STAT_OFS   write one to clear  [0] request seen, [1] block sent.
  //   IRQ_MASK_OFS   read-write  same layout as the interrupt status.
  // Writes to the read-only words and to unmapped addresses are dropped; unmapped
  // reads return zero so software probing the map always sees a clean value.
  // Narrow fields sit in the low bits and the upper bits of every word read zero.

  // Compares the bus address with one register offset; used by every select below.
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    addr_hit = (addr == ofs);
  endfunction

  // Address decode, shared by the write enables and the read multiplexer.
  wire sel_cap = addr_hit(reg_addr, CAP_CFG_OFS);
  wire sel_cnt = addr_hit(reg_addr, BATT_CNT_OFS);
  wire sel_live = addr_hit(reg_addr, LIVE_OFS);
  wire sel_temp = addr_hit(reg_addr, TEMP_OFS);
  wire sel_caps = addr_hit(reg_addr, CAPS_RD_OFS);
  wire sel_stat = addr_hit(reg_addr, STATUS_RD_OFS);
  wire sel_is = addr_hit(reg_addr, IRQ_STAT_OFS);
  wire sel_im = addr_hit(reg_addr, IRQ_MASK_OFS);

  // Write enables, one per writable word.
  wire we_cap = reg_wr & sel_cap;
  wire we_cnt = reg_wr & sel_cnt;
  wire we_live = reg_wr & sel_live;
  wire we_temp = reg_wr & sel_temp;
  wire we_is = reg_wr & sel_is;
  wire we_im = reg_wr & sel_im;

  // Read data selection; unmapped addresses read zero.
  logic [31:0] rd_mux;
  assign rd_mux = sel_cap ? {29'h0, cap_cfg_r} :
                  sel_cnt ? {24'h0, batt_cnt_r} :
                  sel_live ? {21'h0, live_r} :
                  sel_temp ? {24'h0, temp_r} :
                  sel_caps ? {16'h0, batt_byte, inputs_byte} :
                  sel_stat ? {8'h0, battin_byte, present_byte, temp_r} :
                  sel_is ? {30'h0, irq_stat_r} :
                  sel_im ? {30'h0, irq_mask_r} : 32'h0;

  // Events: request taken and block fully sent.
  wire req_take = status_req & (state_r == TX_IDLE);
  wire sent_ev = (state_r == TX_SEND) & tx_ready & (idx_r == LAST_IDX);
  wire [IRQ_W-1:0] ev_vec = {sent_ev, status_req};

  // Read data register; a word stands for one cycle after its strobe, zero otherwise.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 32'h0;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 32'h0;
    end
  end

  // Capability configuration: external, unconstrained and battery input flags.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cap_cfg_r <= 3'h0;
    end else if (we_cap) begin
      cap_cfg_r <= reg_wdata[2:0];
    end
  end

  // Battery counts as written; the limit is applied on the way out, so software reads
  // back exactly what it wrote and can spot its own bad setting.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      batt_cnt_r <= RST_BYTE;
    end else if (we_cnt) begin
      batt_cnt_r <= reg_wdata[7:0];
    end
  end

  // Live supply state; the partner only ever sees it through the per-block snapshot.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      live_r <= 11'h000;
    end else if (we_live) begin
      live_r <= reg_wdata[10:0];
    end
  end

  // Internal temperature byte, kept current by software and forwarded unchanged.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      temp_r <= TEMP_UNSUPPORTED;
    end else if (we_temp) begin
      temp_r <= reg_wdata[7:0];
    end
  end

  // Interrupt mask, same layout as the status word.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_mask_r <= '0;
    end else if (we_im) begin
      irq_mask_r <= reg_wdata[IRQ_W-1:0];
    end
  end

  // Sticky interrupt status; a new event wins over a write-one clear in the same
  // cycle, so an event that lands while software clears its bit is never lost.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~(we_is ? reg_wdata[IRQ_W-1:0] : '0)) | ev_vec;
    end
  end

  // Level interrupt while any unmasked status bit is set; read data from its register.
  assign irq = |(irq_stat_r & irq_mask_r);
  assign reg_rdata = rdata_r;

  // Next-state logic of the block transmitter. A new or a pending request in idle
  // starts a block. Each byte holds until the partner takes it, so a slow receiver
  // only stretches the block and never loses a byte. After the last byte one done
  // cycle passes before idle, which keeps two blocks apart on the stream and gives
  // the pending flag a clean idle cycle in which to start the next block.
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    case (state_r)
      TX_IDLE: begin
        if (status_req || pend_r) begin
          state_nxt = TX_SEND;
          idx_nxt = 2'd0;
        end
      end
      TX_SEND: begin
        if (tx_ready) begin
          if (idx_r == LAST_IDX) begin
            state_nxt = TX_DONE;
          end else begin
            idx_nxt = idx_r + 2'd1;
          end
        end
      end
      default: begin
        state_nxt = TX_IDLE;
      end
    endcase
  end

  // Loads a fresh snapshot on the edge that starts a block.
  wire snap_ld = (state_r == TX_IDLE) & (state_nxt == TX_SEND);

  // Sequencer registers of the transmitter.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= TX_IDLE;
      idx_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
    end
  end

  // A request arriving while busy is remembered so it is still answered; any number
  // of such requests collapse into one further block.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_r <= 1'b0;
    end else if (status_req && !req_take) begin
      pend_r <= 1'b1;
    end else if (state_r == TX_IDLE) begin
      pend_r <= 1'b0;
    end
  end

  // Bytes of the block in the order they are sent.
  logic [7:0] snap_src [0:2];
  assign snap_src[0] = temp_r;
  assign snap_src[1] = present_byte;
  assign snap_src[2] = battin_byte;

  // Snapshot the block at request so the three bytes stay coherent while they are
  // sent, even if software updates the live state in the middle of a block.
  for (genvar g = 0; g < 3; g++) begin : g_snap
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        blk_r[g] <= RST_BYTE;
      end else if (snap_ld) begin
        blk_r[g] <= snap_src[g];
      end
    end
  end

  // Outgoing byte register: byte 0 comes straight from its source as a block starts,
  // then the snapshot byte that the index moves to, and zero outside a block.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_data_r <= RST_BYTE;
    end else if (snap_ld) begin
      tx_data_r <= snap_src[0];
    end else if (state_nxt == TX_SEND) begin
      tx_data_r <= blk_r[idx_nxt];
    end else begin
      tx_data_r <= RST_BYTE;
    end
  end

  // Stream outputs decode the sequencer state.
  assign tx_valid = (state_r == TX_SEND);
  assign tx_data = tx_data_r;
  assign tx_first = tx_valid & (idx_r == 2'h0);
  assign tx_last = tx_valid & (idx_r == LAST_IDX);
  assign tx_size = STATUS_SIZE;

endmodule // source_status_block_builder

// [status_pkg.sv]
// Package with offsets, field positions, reset values and encodings for the status block builder.
package status_pkg;

  // Register byte offsets on the plain register port.
  localparam logic [7:0] CAP_CFG_OFS = 8'h00;
  localparam logic [7:0] BATT_CNT_OFS = 8'h04;
  localparam logic [7:0] LIVE_OFS = 8'h08;
  localparam logic [7:0] TEMP_OFS = 8'h0c;
  localparam logic [7:0] CAPS_RD_OFS = 8'h10;
  localparam logic [7:0] STATUS_RD_OFS = 8'h14;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h18;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h1c;

  // Capability source-inputs bit positions.
  localparam int CAP_EXT_BIT = 0;
  localparam int CAP_UNCON_BIT = 1;
  localparam int CAP_BATT_BIT = 2;

  // Present-input bit positions.
  localparam int PI_EXT_BIT = 1;
  localparam int PI_AC_BIT = 2;
  localparam int PI_BATT_BIT = 3;
  localparam int PI_NONBATT_BIT = 4;

  // Battery count limit per kind.
  localparam logic [3:0] MAX_BATT = 4'h4;

  // Temperature encodings.
  localparam logic [7:0] TEMP_UNSUPPORTED = 8'h00;
  localparam logic [7:0] TEMP_BELOW_2C = 8'h01;
  localparam logic [7:0] TEMP_2C = 8'h02;

  // Status block length in bytes, which is the extended header data size.
  localparam logic [8:0] STATUS_SIZE = 9'h003;

  // Index of the last byte of the status block.
  localparam logic [1:0] LAST_IDX = 2'h2;

  // Interrupt status bit positions.
  localparam int IRQ_REQ_BIT = 0;
  localparam int IRQ_SENT_BIT = 1;
  localparam int IRQ_W = 2;

  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Transmit state machine states.
  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_DONE} tx_state_t;

endpackage

// [cap_fields.sv]
// Capability source-inputs and batteries byte encoder.
`timescale 1ns/1ps
module cap_fields (
  // Requested capability settings
  input wire logic ext_ok,
  input wire logic uncon_ok,
  input wire logic batt_ok,
  input wire logic [3:0] hot_cnt,
  input wire logic [3:0] fixed_cnt,
  // Encoded bytes
  output logic [7:0] inputs_byte,
  output logic [7:0] batt_byte
);
  import status_pkg::*;

  logic [3:0] hot_lim;
  logic [3:0] fixed_lim;

  // Counts above the limit are clipped so a bad setting never goes out.
  assign hot_lim = (hot_cnt > MAX_BATT) ? MAX_BATT : hot_cnt;
  assign fixed_lim = (fixed_cnt > MAX_BATT) ? MAX_BATT : fixed_cnt;

  // Bit 1 only rides on bit 0; bit 2 stands alone; the rest stays zero.
  assign inputs_byte = {5'h00, batt_ok, ext_ok & uncon_ok, ext_ok};
  assign batt_byte = {hot_lim, fixed_lim};

endmodule // cap_fields

// [status_fields.sv]
// Present-input and battery-input byte encoder for the status block.
`timescale 1ns/1ps
module status_fields (
  // Live supply state
  input wire logic ext_cap,
  input wire logic ac_supply,
  input wire logic batt_on,
  input wire logic nonbatt_on,
  input wire logic [7:0] batt_mask,
  // Encoded bytes
  output logic [7:0] present_byte,
  output logic [7:0] battin_byte
);
  import status_pkg::*;

  // External bit mirrors the advertised capability; AC only meaningful with it.
  assign present_byte = {3'h0, nonbatt_on, batt_on, ext_cap & ac_supply, ext_cap, 1'b0};
  // Battery flags only when a battery supplies power.
  assign battin_byte = batt_on ? batt_mask : 8'h00;

endmodule // status_fields

// [status_chk_sva.sv]
// Checker for the status block stream.
`timescale 1ns/1ps
module status_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Stream ports
  input wire logic status_req,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_first,
  input wire logic tx_last,
  input wire logic [8:0] tx_size,
  input wire logic tx_ready
);
  // The middle byte of a block is the present-input byte.
  wire logic mid = tx_valid && !tx_first && !tx_last;
  wire logic acc = tx_valid && tx_ready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_SIZE: assert property (tx_size == 9'h003)
    else $error("size");
  AST_ANSWER: assert property (status_req |-> ##[1:20] tx_valid && tx_first)
    else $error("no answer");
  AST_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("byte lost");
  AST_NEXT: assert property (acc && tx_first |=> mid)
    else $error("no byte 1");
  AST_END: assert property (acc && tx_last |=> !tx_valid)
    else $error("too long");
  AST_RSV: assert property (mid |-> tx_data[0] == 1'b0 && tx_data[7:5] == 3'h0)
    else $error("reserved set");
  AST_AC: assert property (mid && !tx_data[1] |-> !tx_data[2])
    else $error("ac bit");
  AST_BATT: assert property (acc && mid && !tx_data[3] |=> tx_last && tx_data == 8'h00)
    else $error("battery byte");
  cover property (acc && tx_last);
  cover property (tx_valid && !tx_ready);
  cover property (status_req && tx_valid);
endmodule // status_chk

// [ssb_sink.sv]
// Model of the partner logic that takes status blocks.
`timescale 1ns/1ps
module ssb_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Status block stream
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  // Last block taken and block count
  output logic [23:0] got,
  output logic [7:0] nblk,
  // Present-input flags as a receiver reads them
  output logic [3:0] pwr_in
);
  // Stalls every other cycle so every byte after the first must wait; bytes shift in whole.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_ready <= 1'b0;
      got <= 24'h0;
      nblk <= 8'h00;
    end else begin
      tx_ready <= ~tx_ready;
      if (tx_valid && tx_ready) begin
        got <= {got[15:0], tx_data};
        nblk <= nblk + {7'h0, tx_last};
      end
    end
  end

  // Receiver view of the last block: reserved bits are dropped and the AC flag only
  // counts while the external-power flag is set.
  assign pwr_in = {got[12], got[11], got[10] & got[9], got[9]};
endmodule // ssb_sink

// [source_status_block_builder_bench.sv]
// Bench for the source status block builder.
`timescale 1ns/1ps
module source_status_block_builder_bench;
  import status_pkg::*;
  typedef struct {logic [2:0] cfg; logic [7:0] cnt; logic [10:0] live; logic [7:0] temp;
    logic [15:0] caps; logic [23:0] st;} row_t;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic status_req = 1'b0;
  logic [31:0] reg_rdata, v;
  logic tx_valid, tx_first, tx_last, tx_ready, irq;
  logic [7:0] tx_data, nblk;
  logic [8:0] tx_size;
  logic [23:0] got;
  logic [3:0] pwr_in;
  int bad_count = 0;
  int cmp_count = 0;
  row_t rows [4];
  source_status_block_builder u_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .status_req(status_req), .tx_valid(tx_valid), .tx_data(tx_data), .tx_first(tx_first),
    .tx_last(tx_last), .tx_size(tx_size), .tx_ready(tx_ready), .irq(irq));
  ssb_sink u_sink (.clk(clk), .nrst(nrst), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .got(got), .nblk(nblk), .pwr_in(pwr_in));
  // Compare, register access and request tasks.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic req(input int n, input int hold);
    int i;
    i = 0;
    @(posedge clk);
    status_req <= 1'b1;
    repeat (hold) @(posedge clk);
    status_req <= 1'b0;
    while (nblk != 8'(n) && i < 40) begin
      @(posedge clk);
      i++;
    end
    #1;
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Clock and watchdog.
  initial forever #10 clk = ~clk;
  initial begin
    #100000;
    bad_count++;
    conclude();
  end
  // Rows of capability and live settings, then the awkward cases.
  initial begin
    rows[0] = '{3'h1, 8'h21, 11'h000, 8'h01, 16'h2101, 24'h000201};
    rows[1] = '{3'h3, 8'h43, 11'h093, 8'h20, 16'h4303, 24'h120e20};
    rows[2] = '{3'h2, 8'h9f, 11'h7fd, 8'h00, 16'h4400, 24'h001000};
    rows[3] = '{3'h7, 8'h04, 11'h00a, 8'h19, 16'h0407, 24'h010a19};
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd(CAPS_RD_OFS);
    chk(v, 32'h0);
    chk({23'h0, tx_size}, 32'h3);
    $display("reset done");
    foreach (rows[i]) begin
      wr(CAP_CFG_OFS, {29'h0, rows[i].cfg});
      wr(BATT_CNT_OFS, {24'h0, rows[i].cnt});
      wr(LIVE_OFS, {21'h0, rows[i].live});
      wr(TEMP_OFS, {24'h0, rows[i].temp});
      rd(CAPS_RD_OFS);
      chk(v, {16'h0, rows[i].caps});
      rd(STATUS_RD_OFS);
      chk(v, {8'h0, rows[i].st});
      req(i + 1, 1);
      chk({8'h0, got}, {8'h0, rows[i].st[7:0], rows[i].st[15:8], rows[i].st[23:16]});
      chk({28'h0, pwr_in},
        {28'h0, rows[i].live[2:1], rows[i].live[0] & rows[i].cfg[0], rows[i].cfg[0]});
      $display("row %0d done", i);
    end
    chk({31'h0, irq}, 32'h0);
    rd(IRQ_STAT_OFS);
    chk(v, 32'h3);
    wr(IRQ_MASK_OFS, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(IRQ_STAT_OFS, 32'h3);
    chk({31'h0, irq}, 32'h0);
    $display("irq done");
    req(6, 2);
    chk({24'h0, nblk}, 32'h6);
    chk({31'h0, irq}, 32'h1);
    wr(CAPS_RD_OFS, 32'hffff);
    rd(CAPS_RD_OFS);
    chk(v, 32'h0407);
    rd(8'h20);
    chk(v, 32'h0);
    $display("edge cases done");
    rd(CAP_CFG_OFS);
    chk(v, 32'h7);
    rd(BATT_CNT_OFS);
    chk(v, 32'h04);
    rd(LIVE_OFS);
    chk(v, 32'h00a);
    rd(TEMP_OFS);
    chk(v, 32'h19);
    rd(IRQ_MASK_OFS);
    chk(v, 32'h2);
    $display("read back done");
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    #1;
    chk({29'h0, tx_valid, irq, reg_rdata != 32'h0}, 32'h0);
    chk({24'h0, nblk}, 32'h0);
    @(posedge clk);
    nrst <= 1'b1;
    rd(CAPS_RD_OFS);
    chk(v, 32'h0);
    $display("mid-run reset done");
    conclude();
  end
endmodule // source_status_block_builder_bench
bind source_status_block_builder status_chk u_chk (.clk, .nrst, .status_req, .tx_valid,
  .tx_data, .tx_first, .tx_last, .tx_size, .tx_ready);
